// ### dv/adc_link_props.sv
// assertions on the converter link between device end and host end
// assumes the bench hands in the link signals, its clock and reset
module adc_link_props (
    input wire logic I_SYS_CLK,
    input wire logic I_ARST_N,
    input wire logic convert_strobe,
    input wire logic serial_clock,
    input wire logic chain_serial_input,
    input wire logic result_serial_output,
    input wire logic result_oe_n,
    input wire logic line_level
);
    timeunit 1ns;
    timeprecision 100ps;

    logic strobe_q;
    logic sck_q;
    logic gated;
    logic [7:0] since_rise;
    logic [4:0] fall_cnt;
    logic rise;
    logic fall;

    assign rise = convert_strobe & ~strobe_q;
    assign fall = sck_q & ~serial_clock;

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            strobe_q <= 1'b0;
            sck_q <= 1'b0;
            gated <= 1'b1;
        end
        else
        begin
            strobe_q <= convert_strobe;
            sck_q <= serial_clock;
            if (rise)
                gated <= chain_serial_input;
        end
    end

    // cycles since the last strobe rise, saturating
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            since_rise <= 8'hFF;
        else if (rise)
            since_rise <= 8'h01;
        else if (since_rise != 8'hFF)
            since_rise <= since_rise + 8'h01;
    end

    // serial clock falls within the current frame
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            fall_cnt <= 5'h00;
        else if (rise)
            fall_cnt <= 5'h00;
        else if (fall && fall_cnt != 5'h1F)
            fall_cnt <= fall_cnt + 5'h01;
    end

    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_ARST_N);

    a_strobe_held_high: assert property (
        rise |-> convert_strobe[*8]) else $error("strobe pulse too short");
    a_conv_rate_gap: assert property (
        rise |-> since_rise >= 8'h22) else $error("strobes too close");
    a_no_early_read: assert property (
        fall |-> since_rise >= 8'h12) else $error("read before conversion end");
    a_sck_low_at_rise: assert property (
        rise |-> !serial_clock) else $error("serial clock high at strobe rise");
    a_sixteen_falls: assert property (
        rise |-> (fall_cnt == 5'h00 || fall_cnt == 5'h10))
        else $error("frame not sixteen bits");
    a_gate_high_release: assert property (
        (gated && convert_strobe && chain_serial_input)[*8] |-> result_oe_n)
        else $error("line driven while gate high");
    a_last_fall_release: assert property (
        gated && fall && fall_cnt == 5'h0F |-> ##[1:8] result_oe_n)
        else $error("line not released after last bit");
    a_gated_bits_driven: assert property (
        gated && fall && fall_cnt < 5'h0F |-> !result_oe_n)
        else $error("gated line not driven during read");
    a_chain_bits_driven: assert property (
        !gated && fall |-> !result_oe_n)
        else $error("chain line not driven during read");

    c_gated_frame: cover property (gated && fall && fall_cnt == 5'h0F);
    c_chain_frame: cover property (!gated && fall && fall_cnt == 5'h0F);
    c_back_to_back: cover property (rise && since_rise < 8'hC8);
    c_line_low: cover property (!result_oe_n && !line_level);
endmodule

// ### dv/sar_adc_serial_readout_tb.sv
// self-checking bench: device end and host end joined through the link
// assumes both ends share the bench clock and reset
`include "adc_link_consts.svh"

module sar_adc_serial_readout_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [15:0] FIXED [5] = '{16'h0000, 16'hFFFF, 16'h8000,
        16'h0001, 16'h7FFE};

    logic I_SYS_CLK;
    logic I_ARST_N;
    logic I_START;
    logic I_CHAIN_MODE;
    logic [15:0] I_SAMPLE_CODE;
    logic dev_busy;
    logic dev_mode;
    logic dev_valid;
    logic host_busy;
    logic host_valid;
    logic [15:0] dev_result;
    logic [15:0] host_data;
    logic [16:0] dev_q[$];
    logic [15:0] host_q[$];
    logic [16:0] exp_d;
    logic [15:0] lfsr;
    logic strobe_prev;
    int num_errors;
    int n_compared;
    int cycles;
    int conv_t;
    int busy_n;

    adc_link_if adc_link_if_i ();

    adc_device_end adc_device_end_i (
        .I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N), .link(adc_link_if_i),
        .I_SAMPLE_CODE(I_SAMPLE_CODE), .O_BUSY(dev_busy),
        .O_CHAIN_MODE(dev_mode), .O_RESULT(dev_result),
        .O_RESULT_VALID(dev_valid));

    adc_host_end adc_host_end_i (
        .I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N), .link(adc_link_if_i),
        .I_START(I_START), .I_CHAIN_MODE(I_CHAIN_MODE), .O_BUSY(host_busy),
        .O_DATA(host_data), .O_DATA_VALID(host_valid));

    adc_link_props adc_link_props_i (
        .I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N),
        .convert_strobe(adc_link_if_i.convert_strobe),
        .serial_clock(adc_link_if_i.serial_clock),
        .chain_serial_input(adc_link_if_i.chain_serial_input),
        .result_serial_output(adc_link_if_i.result_serial_output),
        .result_oe_n(adc_link_if_i.result_oe_n),
        .line_level(adc_link_if_i.line_level));

    always #25 I_SYS_CLK = ~I_SYS_CLK;

    task automatic cmp_word(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp,
        input logic got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
    endfunction

    // one start, then wait for the read to come back
    task automatic run_frame(input logic [15:0] code, input logic mode);
        int n;
        n = 0;
        I_SAMPLE_CODE = code;
        I_CHAIN_MODE = mode;
        I_START = 1'b1;
        dev_q.push_back({mode, code});
        host_q.push_back(code);
        do
        begin
            @(posedge I_SYS_CLK);
            #5;
            n++;
        end
        while (host_busy !== 1'b1 && n < 40);
        cmp_bit("host busy", 1'b1, host_busy);
        I_START = 1'b0;
        while (host_valid !== 1'b1 && n < 180)
        begin
            @(posedge I_SYS_CLK);
            #5;
            n++;
        end
        cmp_bit("frame done in time", 1'b1, host_valid);
    endtask

    always @(posedge I_SYS_CLK)
    begin
        #2;
        conv_t++;
        if (dev_busy === 1'b1)
            busy_n++;
        if (adc_link_if_i.convert_strobe === 1'b1 && strobe_prev === 1'b0)
        begin
            conv_t = 0;
            busy_n = 0;
        end
        strobe_prev = adc_link_if_i.convert_strobe;
        if (dev_valid === 1'b1)
        begin
            exp_d = dev_q.pop_front();
            cmp_word("device result", exp_d[15:0], dev_result);
            cmp_bit("device chain mode", exp_d[16], dev_mode);
            cmp_bit("conversion time", 1'b1, conv_t >= `ADC_CONV_CYC
                && conv_t <= `ADC_CONV_MAX_CYC);
            cmp_bit("device busy window", 1'b1, busy_n > 0 && dev_busy === 1'b0
                && busy_n <= `ADC_CONV_MAX_CYC);
        end
        if (host_valid === 1'b1)
            cmp_word("host data", host_q.pop_front(), host_data);
    end

    always @(posedge I_SYS_CLK)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial
    begin
        I_SYS_CLK = 1'b0;
        I_ARST_N = 1'b0;
        I_START = 1'b0;
        I_CHAIN_MODE = 1'b0;
        I_SAMPLE_CODE = 16'h0000;
        lfsr = 16'hC833;
        strobe_prev = 1'b0;
        num_errors = 0;
        n_compared = 0;
        cycles = 0;
        conv_t = 0;
        busy_n = 0;
        repeat (8) @(posedge I_SYS_CLK);
        #5;
        I_ARST_N = 1'b1;
        foreach (FIXED[i])
            run_frame(FIXED[i], i[0]);
        for (int i = 0; i < 12; i++)
        begin
            lfsr = lfsr_next(lfsr);
            run_frame(lfsr, lfsr[3]);
        end
        repeat (4) @(posedge I_SYS_CLK);
        cmp_bit("all results seen", 1'b1,
            dev_q.size() == 0 && host_q.size() == 0);
        tally_and_finish();
    end
endmodule

// ### hw/adc_device_end.sv
// converter end: conversion timing, mode select, serial result output
// assumes strobe, serial clock and chain input come from another domain
// Operation
// - each strobe rise samples input, starts conversion
// - sixteen-bit result, every code passes through
// - result readable at once, no pipeline
// - conversion lasts 625 to 900 ns
// - host holds strobe high at least 10 ns
// - host keeps gated-mode clock period legal
// - host keeps chain-mode clock period legal
// - gate low drives output, msb first
// - release output on gate high or last edge; in chain mode the code keeps it driven until the next strobe rise
// - output moves after falling clock edge
// - chain input carries downstream converter result
// - chain input captured on falling clock edges
// - chain busy: output high once chain input high
// - chain input low at strobe rise selects chain
// - chain input reaches output sixteen clocks later
// - gate low at completion enables busy indicator; in chain mode the code enables it on strobe low at completion instead
`include "adc_link_consts.svh"

module adc_device_end (
    input wire logic I_SYS_CLK,
    input wire logic I_ARST_N,
    adc_link_if.device link,
    input wire logic [15:0] I_SAMPLE_CODE,
    output logic O_BUSY,
    output logic O_CHAIN_MODE,
    output logic [15:0] O_RESULT,
    output logic O_RESULT_VALID
);
    logic s_cnv;
    logic s_sck;
    logic s_sdi;
    logic cnv_q;
    logic sck_q;
    logic cnv_rise;
    logic sck_fall;
    logic gate;
    adc_link_pkg::dev_state_type state;
    logic chain_mode;
    logic busy_pending;
    logic [5:0] conv_cnt;
    logic [4:0] bit_cnt;
    logic [15:0] held_code;
    logic [15:0] shreg;
    logic conv_done;
    logic next_sdo;
    logic next_oe_n;

    sync_two_ff #(
        .WIDTH(3)
    ) pin_sync (
        .i_clk(I_SYS_CLK),
        .i_arst_n(I_ARST_N),
        .i_async({link.convert_strobe, link.serial_clock,
                  link.chain_serial_input}),
        .o_sync({s_cnv, s_sck, s_sdi})
    );

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            cnv_q <= 1'b0;
            sck_q <= 1'b0;
        end
        else
        begin
            cnv_q <= s_cnv;
            sck_q <= s_sck;
        end
    end

    assign cnv_rise = s_cnv & ~cnv_q;
    assign sck_fall = ~s_sck & sck_q;
    assign gate = ~s_cnv | ~s_sdi;
    assign conv_done = (state == adc_link_pkg::DEV_CONV) &&
                       (conv_cnt == 6'(`ADC_CONV_CYC - 1));

    // state sequencing
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            state <= adc_link_pkg::DEV_IDLE;
        end
        else if (cnv_rise)
        begin
            state <= adc_link_pkg::DEV_CONV;
        end
        else
        begin
            case (state)
                adc_link_pkg::DEV_IDLE:
                begin
                    state <= adc_link_pkg::DEV_IDLE;
                end
                adc_link_pkg::DEV_CONV:
                begin
                    if (conv_done)
                    begin
                        state <= adc_link_pkg::DEV_DATA;
                    end
                end
                adc_link_pkg::DEV_DATA:
                begin
                    // gated readout finished after sixteen bits
                    if (!chain_mode && bit_cnt == 5'(`ADC_RES_BITS))
                    begin
                        state <= adc_link_pkg::DEV_IDLE;
                    end
                end
                default:
                begin
                    state <= adc_link_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    // sampling, mode choice and conversion timer
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            chain_mode <= 1'b0;
            held_code <= 16'h0000;
            conv_cnt <= 6'h00;
        end
        else if (cnv_rise)
        begin
            chain_mode <= ~s_sdi;
            held_code <= I_SAMPLE_CODE;
            conv_cnt <= 6'h00;
        end
        else if (state == adc_link_pkg::DEV_CONV)
        begin
            conv_cnt <= conv_cnt + 6'h01;
        end
    end

    // result shift register
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            shreg <= 16'h0000;
            bit_cnt <= 5'h00;
            busy_pending <= 1'b0;
        end
        else if (cnv_rise)
        begin
            bit_cnt <= 5'h00;
            busy_pending <= 1'b0;
        end
        else if (conv_done)
        begin
            shreg <= held_code;
            bit_cnt <= 5'h00;
            // chain mode busy when strobe low at completion
            busy_pending <= chain_mode ? ~s_cnv : gate;
        end
        else if (state == adc_link_pkg::DEV_DATA && sck_fall)
        begin
            if (busy_pending)
            begin
                busy_pending <= 1'b0;
            end
            else if (bit_cnt != 5'(`ADC_RES_BITS) || chain_mode)
            begin
                shreg <= {shreg[14:0], chain_mode ? s_sdi : 1'b0};
                if (bit_cnt != 5'(`ADC_RES_BITS))
                begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
            end
        end
    end

    // output line drive
    always_comb
    begin
        next_sdo = 1'b0;
        next_oe_n = 1'b1;
        if (state == adc_link_pkg::DEV_DATA && chain_mode)
        begin
            next_oe_n = 1'b0;
            next_sdo = busy_pending ? s_sdi : shreg[15];
        end
        else if (state == adc_link_pkg::DEV_DATA && gate &&
                 bit_cnt != 5'(`ADC_RES_BITS))
        begin
            next_oe_n = 1'b0;
            // busy end marked low, msb follows first fall
            next_sdo = busy_pending ? 1'b0 : shreg[15];
        end
        else if (state == adc_link_pkg::DEV_CONV && !chain_mode && gate)
        begin
            next_oe_n = 1'b0;
            next_sdo = 1'b1;
        end
    end

    // registered pins, two cycles behind the detected edge
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            link.result_serial_output <= 1'b0;
            link.result_oe_n <= 1'b1;
        end
        else
        begin
            link.result_serial_output <= next_sdo;
            link.result_oe_n <= next_oe_n;
        end
    end

    // user-side status
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_BUSY <= 1'b0;
            O_CHAIN_MODE <= 1'b0;
            O_RESULT <= 16'h0000;
            O_RESULT_VALID <= 1'b0;
        end
        else
        begin
            O_BUSY <= (state == adc_link_pkg::DEV_CONV) && !conv_done;
            O_CHAIN_MODE <= chain_mode;
            O_RESULT_VALID <= conv_done && !cnv_rise;
            if (conv_done && !cnv_rise)
            begin
                O_RESULT <= held_code;
            end
        end
    end
endmodule

// ### hw/adc_host_end.sv
// host end: starts conversions, makes the serial clock, reads result
// assumes the returned data line comes from another domain
`include "adc_link_consts.svh"

module adc_host_end (
    input wire logic I_SYS_CLK,
    input wire logic I_ARST_N,
    adc_link_if.host link,
    input wire logic I_START,
    input wire logic I_CHAIN_MODE,
    output logic O_BUSY,
    output logic [15:0] O_DATA,
    output logic O_DATA_VALID
);
    localparam int WAIT_CYC = `ADC_CONV_MAX_CYC + `HOST_SYNC_MARGIN_CYC;
    localparam int PERIOD_CYC = 2 * `HOST_SCK_HALF_CYC;

    adc_link_pkg::host_state_type state;
    logic s_sdo;
    logic chain;
    logic [5:0] wait_cnt;
    logic [5:0] gap_cnt;
    logic [3:0] div;
    logic [4:0] bit_cnt;
    logic [15:0] shreg;
    logic last_tick;
    logic start_ok;

    sync_two_ff #(
        .WIDTH(1)
    ) sdo_sync (
        .i_clk(I_SYS_CLK),
        .i_arst_n(I_ARST_N),
        .i_async(link.line_level),
        .o_sync(s_sdo)
    );

    assign last_tick = (div == 4'(PERIOD_CYC - 1));
    // start only once the mode level already stands on the chain input
    assign start_ok = I_START && gap_cnt == 6'h00 &&
                      (link.chain_serial_input == ~I_CHAIN_MODE);

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            state <= adc_link_pkg::HOST_IDLE;
            chain <= 1'b0;
            wait_cnt <= 6'h00;
            gap_cnt <= 6'h00;
            div <= 4'h0;
            bit_cnt <= 5'h00;
            shreg <= 16'h0000;
            link.convert_strobe <= 1'b0;
            link.serial_clock <= 1'b0;
            link.chain_serial_input <= 1'b1;
        end
        else
        begin
            if (gap_cnt != 6'h00)
            begin
                gap_cnt <= gap_cnt - 6'h01;
            end
            case (state)
                adc_link_pkg::HOST_IDLE:
                begin
                    // mode level set one cycle before the strobe rises
                    link.chain_serial_input <= ~I_CHAIN_MODE;
                    if (start_ok)
                    begin
                        chain <= I_CHAIN_MODE;
                        link.convert_strobe <= 1'b1;
                        wait_cnt <= 6'h00;
                        gap_cnt <= 6'(`ADC_CYCLE_CYC - 1);
                        state <= adc_link_pkg::HOST_WAIT;
                    end
                end
                adc_link_pkg::HOST_WAIT:
                begin
                    // strobe high for the whole wait, far above the minimum
                    wait_cnt <= wait_cnt + 6'h01;
                    if (wait_cnt == 6'(WAIT_CYC - 1))
                    begin
                        link.convert_strobe <= chain;
                        div <= 4'h0;
                        bit_cnt <= 5'h00;
                        state <= adc_link_pkg::HOST_SHIFT;
                    end
                end
                adc_link_pkg::HOST_SHIFT:
                begin
                    div <= last_tick ? 4'h0 : div + 4'h1;
                    if (div == 4'(`HOST_SCK_HALF_CYC - 1))
                    begin
                        link.serial_clock <= 1'b1;
                    end
                    if (last_tick)
                    begin
                        link.serial_clock <= 1'b0;
                        shreg <= {shreg[14:0], s_sdo};
                        bit_cnt <= bit_cnt + 5'h01;
                        if (bit_cnt == 5'(`ADC_RES_BITS - 1))
                        begin
                            state <= adc_link_pkg::HOST_DONE;
                        end
                    end
                end
                adc_link_pkg::HOST_DONE:
                begin
                    link.convert_strobe <= 1'b0;
                    state <= adc_link_pkg::HOST_IDLE;
                end
                default:
                begin
                    state <= adc_link_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_BUSY <= 1'b0;
            O_DATA <= 16'h0000;
            O_DATA_VALID <= 1'b0;
        end
        else
        begin
            O_BUSY <= (state != adc_link_pkg::HOST_IDLE) || start_ok;
            O_DATA_VALID <= (state == adc_link_pkg::HOST_DONE);
            if (state == adc_link_pkg::HOST_DONE)
            begin
                O_DATA <= shreg;
            end
        end
    end
endmodule

// ### hw/adc_link_consts.svh
// timing and size constants shared by both ends of the converter link
// assumes a 20 MHz system clock on each end
`ifndef ADC_LINK_CONSTS_SVH
`define ADC_LINK_CONSTS_SVH

`define SYS_CLK_NS 50
`define ADC_RES_BITS 16
`define ADC_CONV_MIN_NS 625
`define ADC_CONV_MAX_NS 900
`define ADC_CNVH_MIN_NS 10
`define ADC_CYCLE_MIN_NS 1667
// least times round up, longest times round down
`define ADC_CONV_CYC ((`ADC_CONV_MIN_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define ADC_CONV_MAX_CYC (`ADC_CONV_MAX_NS / `SYS_CLK_NS)
`define ADC_CNVH_CYC ((`ADC_CNVH_MIN_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define ADC_CYCLE_CYC ((`ADC_CYCLE_MIN_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define HOST_SCK_HALF_CYC 4
`define HOST_SYNC_MARGIN_CYC 4

`endif

// ### hw/adc_link_if.sv
// three-wire link between converter and host, plus the data return line
// assumes the bench joins one device end and one host end through it
interface adc_link_if;
    logic convert_strobe;
    logic serial_clock;
    logic chain_serial_input;
    logic result_serial_output;
    logic result_oe_n;
    logic line_level;

    // released line is pulled high
    assign line_level = result_oe_n ? 1'b1 : result_serial_output;

    modport device (
        input convert_strobe,
        input serial_clock,
        input chain_serial_input,
        output result_serial_output,
        output result_oe_n
    );

    modport host (
        output convert_strobe,
        output serial_clock,
        output chain_serial_input,
        input line_level
    );
endinterface

// ### hw/adc_link_pkg.sv
// state types for both ends of the converter link
// assumes nothing beyond the constants header
package adc_link_pkg;

    typedef enum logic [2:0] {
        DEV_IDLE = 3'b001,
        DEV_CONV = 3'b010,
        DEV_DATA = 3'b100
    } dev_state_type;

    typedef enum logic [3:0] {
        HOST_IDLE = 4'b0001,
        HOST_WAIT = 4'b0010,
        HOST_SHIFT = 4'b0100,
        HOST_DONE = 4'b1000
    } host_state_type;

endpackage

// ### hw/sync_two_ff.sv
// two flip-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level or a clock far below the sampling rate
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
